// ===== boost_ctrl.sv
// Control, protection and I2C register slave of a synchronous boost regulator.
// Pins and comparator outputs arrive asynchronously and are synchronised here.
//
// Contract
// RULE_01 - Enable high starts soft-start; low shuts down.
// RULE_02 - Shutdown stops switching and disconnects load.
// RULE_03 - Leave precharge once output reaches input-300mV.
// RULE_04 - Soft-start beyond 2ms without target faults.
// RULE_05 - Overcurrent limits, 2ms shutdown, restart after 1ms.
// RULE_06 - Level select pin picks 3.15V or 3.6V.
// RULE_07 - Target set by pin or I2C, 2.85-4.4V.
// RULE_08 - Light load enters pulse mode until loop exits.
// RULE_09 - Input undervoltage lockout 1.7V rise, 1.6V fall.
// RULE_10 - Over 160C switches off until 20C cooler.
// RULE_11 - Input over 6V switches off until below 5.7V.
// RULE_12 - Enable low discharges output to ground.
// RULE_13 - Extend off-time until current reaches valley.
// RULE_14 - I2C slave address 1110101 reaches five registers.
// RULE_15 - I2C fast mode, up to 400kb/s.
// RULE_16 - Register address auto-increments; reads use restart.
// RULE_17 - Bypass pin low forces pass-through, high auto.
// RULE_18 - Fault holds input-output path high impedance.
`timescale 1ns/100ps
`include "boost_ctrl_defines.svh"
module boost_ctrl #(
  parameter int SS_TIMEOUT_CYC = `SS_TIMEOUT_NS / `CLK_PERIOD_NS,
  parameter int OC_DELAY_CYC   = `OC_DELAY_NS / `CLK_PERIOD_NS,
  parameter int RESTART_CYC    = `RESTART_NS / `CLK_PERIOD_NS,
  parameter int PRECHG_CYC     = `PRECHARGE_TIMEOUT_NS / `CLK_PERIOD_NS
) (
  // Clock and reset.
  input  wire logic                  clk_sys_i,
  input  wire logic                  rst_i,
  // Control pins.
  input  wire logic                  enable_i,
  input  wire logic                  forced_passthrough_n_i,
  input  wire logic                  output_level_select_i,
  // Analogue sense results.
  input  wire boost_ctrl_pkg::sense_t sense_i,
  // Power stage and status.
  output boost_ctrl_pkg::drive_t     drive_o,
  output logic [4:0]                 target_code_o,
  output logic [3:0]                 current_limit_o,
  output logic                       power_good_o,
  output logic                       power_good_oe_o,
  // I2C pins.
  input  wire logic                  scl_i,
  input  wire logic                  sda_i,
  output logic                       sda_o,
  output logic                       sda_oe_o
);
  import boost_ctrl_pkg::*;

  localparam int SW = $bits(sense_t) + 5;
  localparam int CW = 25;

  initial begin
    if (SS_TIMEOUT_CYC < 1 || OC_DELAY_CYC < 1 || RESTART_CYC < 1 ||
        PRECHG_CYC < 1 || SS_TIMEOUT_CYC >= (1 << CW) ||
        OC_DELAY_CYC >= (1 << CW) || RESTART_CYC >= (1 << CW) ||
        PRECHG_CYC >= (1 << CW)) begin
      $error("boost_ctrl: timing count out of range");
    end
  end

  // Three-stage synchronisers; a change counts when stages two and three agree.
  logic [SW-1:0] raw;
  logic [SW-1:0] s1_q;
  logic [SW-1:0] s2_q;
  logic [SW-1:0] s3_q;
  logic [SW-1:0] clean_q;
  // The bus lines idle high, so their stages reset high to avoid a false edge.
  localparam logic [SW-1:0] SYNC_RST = SW'(3);
  assign raw = {sense_i, enable_i, forced_passthrough_n_i,
                output_level_select_i, scl_i, sda_i};
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      s1_q    <= SYNC_RST;
      s2_q    <= SYNC_RST;
      s3_q    <= SYNC_RST;
      clean_q <= SYNC_RST;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < SW; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          clean_q[i] <= s3_q[i];
        end
      end
    end
  end

  sense_t sn;
  logic   en;
  logic   byp_n;
  logic   lvl;
  logic   scl;
  logic   sda;
  assign {sn, en, byp_n, lvl, scl, sda} = clean_q;

  // Registers.
  logic [7:0] mode_control_q;
  logic [7:0] target_low_q;
  logic [7:0] target_high_q;
  logic [7:0] current_limit_q;
  logic [7:0] flags;
  logic       tsd_flag_q;
  logic       ilimpt_flag_q;
  logic       ilimbst_flag_q;
  logic       fault_flag_q;
  logic       hot_q;
  logic       uv_lock_q;
  logic       ov_lock_q;
  logic       ot_lock_q;
  state_t     state_q;
  logic [CW-1:0] tmr_q;
  logic [CW-1:0] oc_tmr_q;

  // I2C slave.
  typedef enum {
    I_IDLE,
    I_ADDR,
    I_ADDR_ACK,
    I_REG,
    I_REG_ACK,
    I_WDATA,
    I_WDATA_ACK,
    I_RDATA,
    I_RDATA_ACK
  } i2c_t;
  i2c_t       i_st_q;
  logic       scl_d1_q;
  logic       sda_d1_q;
  logic [7:0] sh_q;
  logic [3:0] bit_q;
  logic [7:0] ptr_q;
  logic       rd_q;
  logic       sda_lo_q;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_c;
  logic       stop_c;
  logic       wr_stb;
  logic       rd_stb;

  function automatic logic [7:0] read_reg(input logic [7:0] a,
                                          input logic [7:0] fl);
    unique case (a)
      `REG_MODE_CONTROL:  read_reg = mode_control_q;
      `REG_TARGET_LOW:    read_reg = target_low_q;
      `REG_TARGET_HIGH:   read_reg = target_high_q;
      `REG_CURRENT_LIMIT: read_reg = current_limit_q;
      `REG_DEVICE_FLAGS:  read_reg = fl;
      default:            read_reg = 8'h00;
    endcase
  endfunction : read_reg

  logic [7:0] rd_word;
  always_comb begin
    rd_word = read_reg(ptr_q, flags);
  end

  assign scl_rise = scl & ~scl_d1_q;
  assign scl_fall = ~scl & scl_d1_q;
  assign start_c  = scl & scl_d1_q & sda_d1_q & ~sda;
  assign stop_c   = scl & scl_d1_q & ~sda_d1_q & sda;
  assign wr_stb   = (i_st_q == I_WDATA) && scl_fall && bit_q == 4'h8;
  assign rd_stb   = (i_st_q == I_RDATA_ACK) && scl_rise;

  // Fast-mode bit timing is sampled from SCL edges, 400kb/s is ample. RULE_15
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      scl_d1_q <= 1'b1;
      sda_d1_q <= 1'b1;
      i_st_q   <= I_IDLE;
      sh_q     <= 8'h00;
      bit_q    <= 4'h0;
      ptr_q    <= 8'h00;
      rd_q     <= 1'b0;
      sda_lo_q <= 1'b0;
    end else begin
      scl_d1_q <= scl;
      sda_d1_q <= sda;
      if (stop_c) begin
        i_st_q   <= I_IDLE;
        sda_lo_q <= 1'b0;
      end else if (start_c) begin
        i_st_q   <= I_ADDR;
        bit_q    <= 4'h0;
        sda_lo_q <= 1'b0;
      end else begin
        if (scl_rise && (i_st_q == I_ADDR || i_st_q == I_REG ||
                         i_st_q == I_WDATA)) begin
          sh_q  <= {sh_q[6:0], sda};
          bit_q <= bit_q + 4'h1;
        end
        unique case (i_st_q)
          I_IDLE: ;
          I_ADDR, I_REG, I_WDATA: begin
            if (scl_fall && bit_q == 4'h8) begin
              bit_q <= 4'h0;
              if (i_st_q == I_ADDR) begin
                if (sh_q[7:1] == `I2C_SLAVE_ADDR) begin // RULE_14
                  rd_q     <= sh_q[0];
                  sda_lo_q <= 1'b1;
                  i_st_q   <= I_ADDR_ACK;
                end else begin
                  i_st_q <= I_IDLE;
                end
              end else begin
                sda_lo_q <= 1'b1;
                if (i_st_q == I_REG) begin
                  ptr_q  <= sh_q; // RULE_16
                  i_st_q <= I_REG_ACK;
                end else begin
                  ptr_q  <= ptr_q + 8'h01; // RULE_16
                  i_st_q <= I_WDATA_ACK;
                end
              end
            end
          end
          I_ADDR_ACK, I_REG_ACK, I_WDATA_ACK: begin
            if (scl_fall) begin
              if (i_st_q == I_ADDR_ACK && rd_q) begin
                sh_q     <= rd_word;
                sda_lo_q <= ~rd_word[7];
                bit_q    <= 4'h1;
                i_st_q   <= I_RDATA;
              end else begin
                sda_lo_q <= 1'b0;
                i_st_q   <= (i_st_q == I_ADDR_ACK) ? I_REG : I_WDATA;
              end
            end
          end
          I_RDATA: begin
            if (scl_fall) begin
              if (bit_q == 4'h8) begin
                sda_lo_q <= 1'b0;
                i_st_q   <= I_RDATA_ACK;
              end else begin
                sda_lo_q <= ~sh_q[7 - bit_q[2:0]];
                bit_q    <= bit_q + 4'h1;
              end
            end
          end
          I_RDATA_ACK: begin
            if (scl_rise) begin
              if (sda) begin
                i_st_q <= I_IDLE;
              end else begin
                ptr_q  <= ptr_q + 8'h01; // RULE_16
                i_st_q <= I_WDATA_ACK;
                rd_q   <= 1'b1;
              end
            end
          end
        endcase
        if (i_st_q == I_WDATA_ACK && rd_q && scl_fall) begin
          sh_q     <= rd_word;
          sda_lo_q <= ~rd_word[7];
          bit_q    <= 4'h1;
          i_st_q   <= I_RDATA;
        end
      end
      if (start_c && i_st_q == I_IDLE) begin
        rd_q <= 1'b0;
      end
    end
  end

  assign sda_o    = 1'b0;
  assign sda_oe_o = sda_lo_q;

  // Register writes; the pointer holds the address of the byte just taken.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      mode_control_q  <= `RST_MODE_CONTROL;
      target_low_q    <= `RST_TARGET_LOW;
      target_high_q   <= `RST_TARGET_HIGH;
      current_limit_q <= `RST_CURRENT_LIMIT;
    end else if (wr_stb && !rd_q) begin
      unique case (ptr_q)
        `REG_MODE_CONTROL:  mode_control_q  <= sh_q;
        `REG_TARGET_LOW:    target_low_q    <= sh_q; // RULE_07
        `REG_TARGET_HIGH:   target_high_q   <= sh_q; // RULE_07
        `REG_CURRENT_LIMIT: current_limit_q <= sh_q;
        default: ;
      endcase
    end
  end

  // Lockouts with hysteresis.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      uv_lock_q <= 1'b1;
      ov_lock_q <= 1'b0;
      ot_lock_q <= 1'b0;
      hot_q     <= 1'b0;
    end else begin
      if (sn.in_below_input_undervoltage_lockout_fall) uv_lock_q <= 1'b1; // RULE_09
      else if (sn.in_above_input_undervoltage_lockout_rise) uv_lock_q <= 1'b0; // RULE_09
      if (sn.in_above_ovp) ov_lock_q <= 1'b1; // RULE_11
      else if (sn.in_below_ovp_rel) ov_lock_q <= 1'b0; // RULE_11
      if (sn.temp_above_otp) ot_lock_q <= 1'b1; // RULE_10
      else if (sn.temp_below_otp_rel) ot_lock_q <= 1'b0; // RULE_10
      hot_q <= sn.temp_hot;
    end
  end

  logic lockout;
  logic want_on;
  logic want_pass;
  assign lockout = uv_lock_q | ov_lock_q | ot_lock_q;
  always_comb begin
    unique case (mode_control_q[`MC_ENABLE_HI:`MC_ENABLE_LO])
      2'b00: begin
        want_on   = en;
        want_pass = ~byp_n; // RULE_17
      end
      2'b01: begin
        want_on   = en;
        want_pass = 1'b0;
      end
      2'b10: begin
        want_on   = en;
        want_pass = 1'b1;
      end
      default: begin
        want_on   = 1'b0;
        want_pass = 1'b0;
      end
    endcase
  end

  logic oc_active;
  assign oc_active = sn.il_above_limit & ~current_limit_q[`CL_LIMIT_OFF];

  // Overcurrent persistence timer. RULE_05
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !oc_active || state_q == ST_FAULT) begin
      oc_tmr_q <= '0;
    end else if (oc_tmr_q < CW'(OC_DELAY_CYC)) begin
      oc_tmr_q <= oc_tmr_q + 1'b1;
    end
  end

  // Sequencer.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_q <= ST_SHUTDOWN;
      tmr_q   <= '0;
    end else begin
      tmr_q <= tmr_q + 1'b1;
      if (!want_on || lockout) begin
        state_q <= ST_SHUTDOWN; // RULE_01
        tmr_q   <= '0;
      end else begin
        unique case (state_q)
          ST_SHUTDOWN: begin
            state_q <= want_pass ? ST_PASSTHRU : ST_PRECHARGE; // RULE_01
            tmr_q   <= '0;
          end
          ST_PRECHARGE: begin
            if (sn.vout_near_vin) begin
              state_q <= ST_SOFT_START; // RULE_03
              tmr_q   <= '0;
            end else if (tmr_q >= CW'(PRECHG_CYC)) begin
              state_q <= ST_FAULT;
              tmr_q   <= '0;
            end
          end
          ST_SOFT_START: begin
            if (sn.vout_at_target) begin
              state_q <= ST_RUN;
            end else if (tmr_q >= CW'(SS_TIMEOUT_CYC)) begin
              state_q <= ST_FAULT; // RULE_04
              tmr_q   <= '0;
            end
          end
          ST_RUN, ST_PASSTHRU: begin
            if (oc_tmr_q >= CW'(OC_DELAY_CYC)) begin
              state_q <= ST_FAULT; // RULE_05
              tmr_q   <= '0;
            end else if (want_pass != (state_q == ST_PASSTHRU)) begin
              state_q <= ST_SHUTDOWN;
            end
          end
          ST_FAULT: begin
            if (tmr_q >= CW'(RESTART_CYC) - 1'b1) begin
              state_q <= ST_PRECHARGE; // RULE_05
              tmr_q   <= '0;
            end
          end
        endcase
      end
    end
  end

  // Status flags; sticky bits clear on readout, a new event wins.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      tsd_flag_q     <= 1'b0;
      ilimpt_flag_q  <= 1'b0;
      ilimbst_flag_q <= 1'b0;
      fault_flag_q   <= 1'b0;
    end else begin
      if (rd_stb && ptr_q == `REG_DEVICE_FLAGS) begin
        tsd_flag_q     <= 1'b0;
        ilimpt_flag_q  <= 1'b0;
        ilimbst_flag_q <= 1'b0;
        fault_flag_q   <= 1'b0;
      end
      if (ot_lock_q) tsd_flag_q <= 1'b1;
      if (oc_active && state_q == ST_PASSTHRU) ilimpt_flag_q <= 1'b1;
      if (oc_active && state_q == ST_RUN) ilimbst_flag_q <= 1'b1;
      if (state_q == ST_FAULT) fault_flag_q <= 1'b1;
    end
  end

  logic pg;
  assign pg = (state_q == ST_RUN) || (state_q == ST_PASSTHRU);
  always_comb begin
    flags              = 8'h00;
    flags[`FL_TSD]     = tsd_flag_q;
    flags[`FL_HOTDIE]  = hot_q;
    flags[`FL_DCDC]    = (state_q == ST_RUN) & ~sn.vout_below_psm;
    flags[`FL_OPMODE]  = (state_q == ST_RUN) || (state_q == ST_SOFT_START);
    flags[`FL_ILIMPT]  = ilimpt_flag_q;
    flags[`FL_ILIMBST] = ilimbst_flag_q;
    flags[`FL_FAULT]   = fault_flag_q;
    flags[`FL_PGOOD]   = pg;
  end

  // Power stage drive, all from flip-flops.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      drive_o         <= '0;
      target_code_o   <= 5'h00;
      current_limit_o <= 4'h0;
      power_good_oe_o <= 1'b1;
    end else begin
      drive_o <= '0;
      if (state_q == ST_SHUTDOWN && !want_on) begin
        drive_o.discharge <= 1'b1; // RULE_12
      end
      if (state_q == ST_SOFT_START || state_q == ST_RUN) begin // RULE_02
        drive_o.high_side_switch <= 1'b1;
        drive_o.low_side_switch  <= 1'b1;
        drive_o.on_time_allow    <= ~sn.il_above_valley & ~oc_active; // RULE_13
        drive_o.light_load_pulse_mode <= (state_q == ST_RUN) &
                                         sn.vout_below_psm; // RULE_08
      end
      if (state_q == ST_PASSTHRU || state_q == ST_PRECHARGE) begin
        drive_o.bypass_switch <= 1'b1;
      end
      // The fault state leaves every switch open. RULE_18
      target_code_o <= lvl ? target_high_q[4:0] : target_low_q[4:0]; // RULE_06
      current_limit_o <= current_limit_q[3:0];
      power_good_oe_o <= ~pg;
    end
  end

  assign power_good_o = 1'b0;
endmodule : boost_ctrl

// ===== boost_ctrl_defines.svh
// Offsets, field positions, reset values and timings in nanoseconds of the boost control block.
// It is included by the package and the design; it holds definitions only.
`ifndef BOOST_CTRL_DEFINES_SVH
`define BOOST_CTRL_DEFINES_SVH
`define I2C_SLAVE_ADDR        7'h75
`define REG_MODE_CONTROL      8'h01
`define REG_TARGET_LOW        8'h02
`define REG_TARGET_HIGH       8'h03
`define REG_CURRENT_LIMIT     8'h04
`define REG_DEVICE_FLAGS      8'h05
`define RST_MODE_CONTROL      8'h09
`define RST_TARGET_LOW        8'h06
`define RST_TARGET_HIGH       8'h0F
`define RST_CURRENT_LIMIT     8'h1D
`define MC_ENABLE_HI          6
`define MC_ENABLE_LO          5
`define CL_LIMIT_OFF          5
`define FL_TSD                7
`define FL_HOTDIE             6
`define FL_DCDC               5
`define FL_OPMODE             4
`define FL_ILIMPT             3
`define FL_ILIMBST            2
`define FL_FAULT              1
`define FL_PGOOD              0
`define CLK_PERIOD_NS         5
`define SS_TIMEOUT_NS         2000000
`define OC_DELAY_NS           2000000
`define RESTART_NS            1000000
`define PRECHARGE_TIMEOUT_NS  1024000
`endif

// ===== boost_ctrl_pkg.sv
// Types shared by the boost control block.
// Assumes the defines header is compiled with it.
`include "boost_ctrl_defines.svh"
package boost_ctrl_pkg;
  typedef enum {
    ST_SHUTDOWN,
    ST_PRECHARGE,
    ST_SOFT_START,
    ST_RUN,
    ST_PASSTHRU,
    ST_FAULT
  } state_t;

  // Analogue comparator results, all active high.
  typedef struct packed {
    logic vout_near_vin;
    logic vout_at_target;
    logic vout_below_psm;
    logic in_above_input_undervoltage_lockout_rise;
    logic in_below_input_undervoltage_lockout_fall;
    logic in_above_ovp;
    logic in_below_ovp_rel;
    logic temp_above_otp;
    logic temp_below_otp_rel;
    logic temp_hot;
    logic il_above_limit;
    logic il_above_valley;
  } sense_t;

  // Power stage controls.
  typedef struct packed {
    logic high_side_switch;
    logic low_side_switch;
    logic bypass_switch;
    logic discharge;
    logic light_load_pulse_mode;
    logic on_time_allow;
  } drive_t;
endpackage : boost_ctrl_pkg

// ===== boost_ctrl_properties.sv
// Checker of the boost control block, bound to its top module.
// Assumes the package is compiled first and one clock domain.
`timescale 1ns/100ps
module boost_ctrl_properties #(
  parameter int OC_DELAY_CYC = 40
) (
  // Clock and reset.
  input wire logic                   clk_sys_i,
  input wire logic                   rst_i,
  // Pins and sense results.
  input wire logic                   enable_i,
  input wire logic                   forced_passthrough_n_i,
  input wire logic                   output_level_select_i,
  input wire boost_ctrl_pkg::sense_t sense_i,
  // Outputs and I2C pins.
  input wire boost_ctrl_pkg::drive_t drive_o,
  input wire logic [4:0]             target_code_o,
  input wire logic [3:0]             current_limit_o,
  input wire logic                   power_good_o,
  input wire logic                   power_good_oe_o,
  input wire logic                   scl_i,
  input wire logic                   sda_i,
  input wire logic                   sda_o,
  input wire logic                   sda_oe_o
);
  import boost_ctrl_pkg::*;
  logic sw_any;
  int   oc_cnt;
  assign sw_any = drive_o.high_side_switch | drive_o.low_side_switch |
                  drive_o.bypass_switch;
  // Counts how long the overcurrent comparator has stood high.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !sense_i.il_above_limit) begin
      oc_cnt <= 0;
    end else if (oc_cnt < 1000) begin
      oc_cnt <= oc_cnt + 1;
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  sequence en_low_s;
    !enable_i [*8];
  endsequence
  sequence pass_s;
    (enable_i && !forced_passthrough_n_i) [*8];
  endsequence
  shutdown_off_a: assert property (en_low_s |-> !sw_any)
    else $error("switches on while enable is low");
  discharge_on_a: assert property (en_low_s |-> drive_o.discharge)
    else $error("no discharge while enable is low");
  ovp_off_a: assert property (
    sense_i.in_above_ovp [*8] |-> !sw_any)
    else $error("switches on during input overvoltage");
  otp_off_a: assert property (
    sense_i.temp_above_otp [*8] |-> !sw_any)
    else $error("switches on during overtemperature");
  input_undervoltage_lockout_off_a: assert property (
    sense_i.in_below_input_undervoltage_lockout_fall [*8] |-> !sw_any)
    else $error("switches on during input undervoltage");
  valley_hold_a: assert property (
    sense_i.il_above_valley [*8] |-> !drive_o.on_time_allow)
    else $error("on-time allowed above valley current");
  oc_shut_a: assert property (oc_cnt == OC_DELAY_CYC + 8 |-> !sw_any)
    else $error("no shutdown after overcurrent delay");
  pass_only_a: assert property (pass_s |->
    !drive_o.high_side_switch && !drive_o.low_side_switch)
    else $error("boost switches on in pass-through");
  sda_edge_a: assert property (
    $changed(sda_oe_o) |-> !scl_i && !$past(scl_i))
    else $error("data line moved while clock high");
endmodule : boost_ctrl_properties
bind boost_ctrl boost_ctrl_properties #(
  .OC_DELAY_CYC(OC_DELAY_CYC)
) u_boost_ctrl_properties (
  .clk_sys_i             (clk_sys_i),
  .rst_i                 (rst_i),
  .enable_i              (enable_i),
  .forced_passthrough_n_i(forced_passthrough_n_i),
  .output_level_select_i (output_level_select_i),
  .sense_i               (sense_i),
  .drive_o               (drive_o),
  .target_code_o         (target_code_o),
  .current_limit_o       (current_limit_o),
  .power_good_o          (power_good_o),
  .power_good_oe_o       (power_good_oe_o),
  .scl_i                 (scl_i),
  .sda_i                 (sda_i),
  .sda_o                 (sda_o),
  .sda_oe_o              (sda_oe_o)
);

// ===== i2c_host_model.sv
// Host controller model that masters the I2C bus of the boost block.
// Assumes the bench resolves SDA with a pull-up; SCL is driven outright.
`timescale 1ns/100ps
module i2c_host_model #(
  parameter int Q = 125
) (
  input  wire logic clk_sys_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_oe_o
);
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end
  // One quarter of a 400kb/s bit at the 200MHz clock.
  task automatic q_wait;
    repeat (Q) @(posedge clk_sys_i);
    #1;
  endtask : q_wait
  task automatic start_cond;
    sda_oe_o = 1'b0;
    q_wait();
    scl_o = 1'b1;
    q_wait();
    sda_oe_o = 1'b1;
    q_wait();
    scl_o = 1'b0;
    q_wait();
  endtask : start_cond
  task automatic xfer_bit(input logic b, output logic r);
    sda_oe_o = ~b;
    q_wait();
    scl_o = 1'b1;
    q_wait();
    r = sda_i;
    q_wait();
    scl_o = 1'b0;
    q_wait();
  endtask : xfer_bit
  task automatic xfer_byte(input logic [7:0] d, input logic ak,
                           output logic [7:0] r, output logic ak_r);
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(d[i], r[i]);
    end
    xfer_bit(ak, ak_r);
  endtask : xfer_byte
  task automatic stop_cond;
    sda_oe_o = 1'b1;
    q_wait();
    scl_o = 1'b1;
    q_wait();
    sda_oe_o = 1'b0;
    q_wait();
  endtask : stop_cond
endmodule : i2c_host_model

// ===== boost_ctrl_tb.sv
// Self-checking bench of the boost control block with an I2C host model.
// Assumes the package, defines header, checker and model compile first.
`timescale 1ns/100ps
`include "boost_ctrl_defines.svh"
`define CHK(a, e) \
  begin \
    checks++; \
    if ((a) !== (e)) begin \
      n_mismatch++; \
      $display("Error at %0t: got %0h exp %0h", $time, (a), (e)); \
    end \
  end
module boost_ctrl_tb;
  import boost_ctrl_pkg::*;
  localparam int SS = 50;
  localparam int OC = 40;
  localparam int RS = 20;
  logic       clk_sys_i = 1'b0;
  logic       rst_i = 1'b1;
  logic       en = 1'b0;
  logic       byp_n = 1'b1;
  logic       lvl = 1'b0;
  sense_t     sn;
  drive_t     drv;
  logic [4:0] tgt;
  logic [3:0] ilim;
  logic       scl;
  logic       dut_oe;
  logic       host_oe;
  logic       pg_oe;
  logic [7:0] rd;
  logic       ak;
  int         n;
  int         n_mismatch = 0;
  int         checks = 0;
  wire logic  sda = ~(dut_oe | host_oe);
  wire logic  sw_any = drv.high_side_switch | drv.low_side_switch |
                       drv.bypass_switch;
  always #2.5 clk_sys_i = ~clk_sys_i;
  boost_ctrl #(
    .SS_TIMEOUT_CYC(SS),
    .OC_DELAY_CYC  (OC),
    .RESTART_CYC   (RS),
    .PRECHG_CYC    (60)
  ) u_boost_ctrl (
    .clk_sys_i             (clk_sys_i),
    .rst_i                 (rst_i),
    .enable_i              (en),
    .forced_passthrough_n_i(byp_n),
    .output_level_select_i (lvl),
    .sense_i               (sn),
    .drive_o               (drv),
    .target_code_o         (tgt),
    .current_limit_o       (ilim),
    .power_good_o          (),
    .power_good_oe_o       (pg_oe),
    .scl_i                 (scl),
    .sda_i                 (sda),
    .sda_o                 (),
    .sda_oe_o              (dut_oe)
  );
  i2c_host_model u_host (
    .clk_sys_i(clk_sys_i),
    .sda_i    (sda),
    .scl_o    (scl),
    .sda_oe_o (host_oe)
  );
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict
  task automatic tick(input int c);
    repeat (c) @(posedge clk_sys_i);
    #1;
  endtask : tick
  task automatic xb(input logic [7:0] d, input logic a);
    u_host.xfer_byte(d, a, rd, ak);
  endtask : xb
  // Waits for switch activity to reach v; running out ends the run.
  task automatic wait_sw(input logic v, input int lim);
    n = 0;
    while (sw_any !== v) begin
      tick(1);
      n++;
      if (n > lim) begin
        `CHK(sw_any, v)
        print_verdict();
      end
    end
  endtask : wait_sw
  task automatic t_regs;
    logic [7:0] exp [6] = '{8'h09, 8'h06, 8'h0F, 8'h1D, 8'h00, 8'h00};
    u_host.start_cond();
    xb({`I2C_SLAVE_ADDR, 1'b0}, 1'b1);
    `CHK(ak, 1'b0)
    xb(`REG_MODE_CONTROL, 1'b1);
    u_host.start_cond();
    xb({`I2C_SLAVE_ADDR, 1'b1}, 1'b1);
    `CHK(ak, 1'b0)
    for (int k = 0; k < 6; k++) begin
      xb(8'hFF, k == 5);
      `CHK(rd, exp[k])
    end
    u_host.stop_cond();
  endtask : t_regs
  task automatic t_target;
    tick(8);
    `CHK(tgt, 5'h06)
    `CHK(ilim, 4'hD)
    lvl = 1'b1;
    tick(8);
    `CHK(tgt, 5'h0F)
    u_host.start_cond();
    xb({`I2C_SLAVE_ADDR, 1'b0}, 1'b1);
    xb(`REG_TARGET_LOW, 1'b1);
    xb(8'h10, 1'b1);
    xb(8'h1A, 1'b1);
    `CHK(ak, 1'b0)
    u_host.stop_cond();
    tick(8);
    `CHK(tgt, 5'h1A)
    lvl = 1'b0;
    tick(8);
    `CHK(tgt, 5'h10)
    u_host.start_cond();
    xb({`I2C_SLAVE_ADDR ^ 7'h01, 1'b0}, 1'b1);
    `CHK(ak, 1'b1)
    u_host.stop_cond();
  endtask : t_target
  task automatic t_run;
    en = 1'b1;
    tick(10);
    `CHK({drv.bypass_switch, drv.low_side_switch}, 2'b10)
    sn.vout_near_vin = 1'b1;
    tick(10);
    `CHK(drv.low_side_switch | drv.high_side_switch, 1'b1)
    sn.vout_at_target = 1'b1;
    tick(20);
    `CHK(pg_oe, 1'b0)
  endtask : t_run
  task automatic set_lock(input int k, input logic v);
    case (k)
      0: {sn.in_below_input_undervoltage_lockout_fall, sn.in_above_input_undervoltage_lockout_rise} = {v, !v};
      1: {sn.in_above_ovp, sn.in_below_ovp_rel} = {v, !v};
      default: {sn.temp_above_otp, sn.temp_below_otp_rel} = {v, !v};
    endcase
  endtask : set_lock
  task automatic t_lock;
    for (int k = 0; k < 3; k++) begin
      set_lock(k, 1'b1);
      wait_sw(1'b0, 40);
      `CHK(n <= 8, 1'b1)
      tick(10);
      set_lock(k, 1'b0);
      wait_sw(1'b1, 40);
      tick(30);
    end
  endtask : t_lock
  task automatic t_oc;
    sn.il_above_limit = 1'b1;
    wait_sw(1'b0, OC + 30);
    `CHK(n >= OC && n <= OC + 10, 1'b1)
    tick(10);
    sn.il_above_limit = 1'b0;
    wait_sw(1'b1, RS + 30);
    `CHK(n + 10 >= RS - 2 && n + 10 <= RS + 12, 1'b1)
    tick(30);
    sn.il_above_valley = 1'b1;
    tick(10);
    `CHK(drv.on_time_allow, 1'b0)
    sn.il_above_valley = 1'b0;
    sn.vout_below_psm = 1'b1;
    tick(10);
    `CHK(drv.light_load_pulse_mode, 1'b1)
    sn.vout_below_psm = 1'b0;
    byp_n = 1'b0;
    tick(10);
    `CHK({drv.high_side_switch, drv.low_side_switch}, 2'b00)
    `CHK(drv.bypass_switch, 1'b1)
    byp_n = 1'b1;
    tick(20);
  endtask : t_oc
  task automatic t_ss;
    en = 1'b0;
    tick(10);
    `CHK({sw_any, drv.discharge, pg_oe}, 3'b011)
    sn.vout_at_target = 1'b0;
    en = 1'b1;
    wait_sw(1'b1, 20);
    wait_sw(1'b0, SS + 30);
    `CHK(n >= SS && n <= SS + 12, 1'b1)
    wait_sw(1'b1, RS + 30);
    `CHK(n >= RS && n <= RS + 12, 1'b1)
  endtask : t_ss
  task automatic wr_mode(input logic [7:0] v);
    u_host.start_cond();
    xb({`I2C_SLAVE_ADDR, 1'b0}, 1'b1);
    xb(`REG_MODE_CONTROL, 1'b1);
    xb(v, 1'b1);
    u_host.stop_cond();
    tick(10);
  endtask : wr_mode
  task automatic t_mode;
    wr_mode(8'h69);
    `CHK({sw_any, drv.discharge, pg_oe}, 3'b011)
    wr_mode(8'h49);
    `CHK({drv.bypass_switch, drv.high_side_switch, pg_oe}, 3'b100)
  endtask : t_mode
  initial begin
    sn = '0;
    sn.in_above_input_undervoltage_lockout_rise = 1'b1;
    sn.in_below_ovp_rel = 1'b1;
    sn.temp_below_otp_rel = 1'b1;
    tick(8);
    rst_i = 1'b0;
    tick(8);
    t_regs();
    t_target();
    t_run();
    t_lock();
    t_oc();
    t_ss();
    t_mode();
    print_verdict();
  end
endmodule : boost_ctrl_tb
